// File: design/flow_pkg.sv
/*
 * Shared constants for the conditional skip and branch unit.
 * Assumes a word-addressed program memory and an 8-bit datapath.
 */
package flow_pkg;
    // Program counter width in bits; the counter addresses words
    localparam int PC_W = 16;
    // Reset value of the program counter
    localparam logic [15:0] PC_RESET = 16'h0000;
    // Reset value of the flag copy
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // Skip distances in words
    localparam logic [15:0] SKIP_ONE = 16'h0002;
    localparam logic [15:0] SKIP_TWO = 16'h0003;
    // Sequential step
    localparam logic [15:0] STEP = 16'h0001;
    // Status flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    // Offset field width
    localparam int OFS_W = 7;

    // Operation codes presented by the decoder
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_SKIP_REG_CLR = 4'h1,
        OP_SKIP_REG_SET = 4'h2,
        OP_SKIP_IO_CLR = 4'h3,
        OP_SKIP_IO_SET = 4'h4,
        OP_BR_FLAG_SET = 4'h5,
        OP_BR_FLAG_CLR = 4'h6,
        OP_BR_EQ = 4'h7,
        OP_BR_NE = 4'h8,
        OP_BR_CS = 4'h9,
        OP_BR_CC = 4'ha
    } flow_op_t;
endpackage : flow_pkg

// File: design/cond_eval.sv
/*
 * Condition evaluator: picks the tested bit and decides taken or not.
 * Assumes operands are stable in the cycle an operation is issued.
 */
`timescale 1ns/10ps
`default_nettype none
module cond_eval
    import flow_pkg::*;
(
    // Operation
    input wire flow_op_t op_i,
    input wire logic [2:0] bit_sel_i,
    // Operands
    input wire logic [7:0] reg_val_i,
    input wire logic [7:0] io_val_i,
    input wire logic [7:0] flags_i,
    // Decision
    output logic taken_o,
    output logic is_skip_o
);
    // Selected operand bits
    wire logic reg_bit = reg_val_i[bit_sel_i];
    wire logic io_bit = io_val_i[bit_sel_i];
    wire logic flag_bit = flags_i[bit_sel_i];

    // Decision table
    always_comb begin
        taken_o = 1'b0;
        is_skip_o = 1'b0;
        case (op_i)
            OP_SKIP_REG_CLR: begin
                is_skip_o = 1'b1;
                taken_o = ~reg_bit;
            end
            OP_SKIP_REG_SET: begin
                is_skip_o = 1'b1;
                taken_o = reg_bit;
            end
            OP_SKIP_IO_CLR: begin
                is_skip_o = 1'b1;
                taken_o = ~io_bit;
            end
            OP_SKIP_IO_SET: begin
                is_skip_o = 1'b1;
                taken_o = io_bit;
            end
            OP_BR_FLAG_SET: taken_o = flag_bit;
            OP_BR_FLAG_CLR: taken_o = ~flag_bit;
            OP_BR_EQ: taken_o = flags_i[FLAG_Z];
            OP_BR_NE: taken_o = ~flags_i[FLAG_Z];
            OP_BR_CS: taken_o = flags_i[FLAG_C];
            OP_BR_CC: taken_o = ~flags_i[FLAG_C];
            default: taken_o = 1'b0;
        endcase
    end
endmodule : cond_eval
`default_nettype wire

// File: design/cond_skip_branch_unit.sv
/*
 * Program flow unit: conditional skips and relative branches update
 * the program counter with the cycle cost of each case.
 * Assumes the decoder holds op_i one cycle while issue_i pulses and
 * reports whether the following instruction is two words long.
 */
// Operation
// - Register bit clear skips next instruction
// - Register bit set skips next instruction
// - I/O bit clear skips next instruction
// - I/O bit set skips next instruction
// - Selected flag set takes relative branch
// - Selected flag clear takes relative branch
// - Zero flag set takes branch
// - Zero flag clear takes branch
// - Carry set takes branch
// - Carry clear takes branch
`timescale 1ns/10ps
`default_nettype none
module cond_skip_branch_unit
    import flow_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Issue from decoder
    input wire logic issue_i,
    input wire flow_op_t op_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [OFS_W-1:0] offset_i,
    input wire logic next_two_word_i,
    // Operands
    input wire logic [7:0] reg_val_i,
    input wire logic [7:0] io_val_i,
    input wire logic [7:0] flags_i,
    // Program flow
    output logic [PC_W-1:0] pc_o,
    output logic busy_o,
    output logic taken_o,
    output logic [7:0] flags_o
);
    // Assertions below share the core clock and the reset
    default clocking chk_cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // State of the multi-cycle sequence
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT1 = 2'b01,
        ST_WAIT2 = 2'b10
    } seq_state_t;

    // Sequence state and its next value
    seq_state_t state_r;
    seq_state_t state_nxt;
    // Program counter and its next value
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    // Busy flag, registered so the port is a flop
    logic busy_r;
    // Taken pulse for the cycle after an issue
    logic taken_r;
    // Pass-through copy of the status flags
    logic [7:0] flags_r;
    // Decision of the evaluator
    logic cond_taken;
    // High when the operation is a skip
    logic cond_skip;

    // Condition decision
    cond_eval u_eval (
        .op_i(op_i),
        .bit_sel_i(bit_sel_i),
        .reg_val_i(reg_val_i),
        .io_val_i(io_val_i),
        .flags_i(flags_i),
        .taken_o(cond_taken),
        .is_skip_o(cond_skip)
    );

    // Accept only when idle
    wire logic accept = issue_i && (state_r == ST_IDLE);
    // Sign-extended word displacement
    wire logic [PC_W-1:0] ofs_ext =
        {{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i};
    // Skip distance by length of the passed instruction
    wire logic [PC_W-1:0] skip_dist = next_two_word_i ? SKIP_TWO : SKIP_ONE;
    // Target selection
    wire logic [PC_W-1:0] tgt_pc = !cond_taken ? pc_r + STEP :
        cond_skip ? pc_r + skip_dist : pc_r + ofs_ext + STEP;

    // Next state and PC
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    pc_nxt = tgt_pc;
                    if (cond_taken && cond_skip && next_two_word_i) begin
                        state_nxt = ST_WAIT2;
                    end else if (cond_taken) begin
                        state_nxt = ST_WAIT1;
                    end
                end
            end
            ST_WAIT2: state_nxt = ST_WAIT1;
            ST_WAIT1: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state_r <= ST_IDLE;
            pc_r <= PC_RESET;
            busy_r <= 1'b0;
            taken_r <= 1'b0;
            flags_r <= FLAGS_RESET;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            // Busy follows the state the sequence is entering
            busy_r <= (state_nxt != ST_IDLE);
            taken_r <= accept && cond_taken;
            flags_r <= flags_i;
        end
    end

    // Outputs straight from the registers
    assign pc_o = pc_r;
    assign busy_o = busy_r;
    assign taken_o = taken_r;
    assign flags_o = flags_r;

    // Checks, clocked and disabled by the defaults above

    // Taken branch lands on pc plus offset plus one
    a_branch_target: assert property (
        accept && cond_taken && !cond_skip |=>
        pc_r == $past(pc_r) + $past(ofs_ext) + STEP)
        else $error("branch target wrong");

    // Taken skip passes over the next instruction
    a_skip_target: assert property (
        accept && cond_taken && cond_skip |=>
        pc_r == $past(pc_r) + $past(skip_dist))
        else $error("skip target wrong");

    // Not taken: next word, no extra cycle
    a_fall_through: assert property (
        accept && !cond_taken |=>
        pc_r == $past(pc_r) + STEP && !busy_o)
        else $error("fall through wrong");

    // Skip over a two-word instruction costs three cycles
    a_skip_three: assert property (
        accept && cond_taken && cond_skip && next_two_word_i |=>
        busy_o [*2] ##1 !busy_o)
        else $error("three cycle skip wrong");

    // Taken branch or short skip costs two cycles
    a_taken_two: assert property (
        accept && cond_taken && !(cond_skip && next_two_word_i) |=>
        busy_o ##1 !busy_o)
        else $error("two cycle case wrong");

    // Register bit clear skip decides on the selected bit
    a_reg_clr_skip: assert property (
        accept && op_i == OP_SKIP_REG_CLR |=>
        taken_r == !$past(reg_val_i[bit_sel_i]))
        else $error("register clear skip wrong");

    // Register bit set skip decides on the selected bit
    a_reg_set_skip: assert property (
        accept && op_i == OP_SKIP_REG_SET |=>
        taken_r == $past(reg_val_i[bit_sel_i]))
        else $error("register set skip wrong");

    // I/O bit clear skip decides on the selected bit
    a_io_clr_skip: assert property (
        accept && op_i == OP_SKIP_IO_CLR |=>
        taken_r == !$past(io_val_i[bit_sel_i]))
        else $error("io clear skip wrong");

    // I/O bit set skip decides on the selected bit
    a_io_skip: assert property (
        accept && op_i == OP_SKIP_IO_SET |=>
        taken_r == $past(io_val_i[bit_sel_i]))
        else $error("io skip wrong");

    // Branch on a selected flag that is set
    a_flag_set_br: assert property (
        accept && op_i == OP_BR_FLAG_SET |=>
        taken_r == $past(flags_i[bit_sel_i]))
        else $error("flag set branch wrong");

    // Branch on a selected flag that is clear
    a_flag_clr_br: assert property (
        accept && op_i == OP_BR_FLAG_CLR |=>
        taken_r == !$past(flags_i[bit_sel_i]))
        else $error("flag clear branch wrong");

    // Branch on zero flag set
    a_eq_branch: assert property (
        accept && op_i == OP_BR_EQ |=>
        taken_r == $past(flags_i[FLAG_Z]))
        else $error("equal branch wrong");

    // Branch on zero flag clear
    a_ne_branch: assert property (
        accept && op_i == OP_BR_NE |=>
        taken_r != $past(flags_i[FLAG_Z]))
        else $error("not equal branch wrong");

    // Branch on carry set
    a_cs_branch: assert property (
        accept && op_i == OP_BR_CS |=>
        taken_r == $past(flags_i[FLAG_C]))
        else $error("carry set branch wrong");

    // Branch on carry clear
    a_cc_branch: assert property (
        accept && op_i == OP_BR_CC |=>
        taken_r != $past(flags_i[FLAG_C]))
        else $error("carry clear branch wrong");

    // Flags pass through untouched
    a_flags_kept: assert property (
        accept |=>
        flags_o == $past(flags_i))
        else $error("flags altered");

    // An issue during the extra cycles is dropped
    a_busy_refuse: assert property (
        busy_o |=>
        pc_r == $past(pc_r) && !taken_r)
        else $error("issue accepted while busy");

    // Taken pulse lasts one cycle only
    a_pulse_single: assert property (
        taken_o |=>
        !taken_o)
        else $error("taken pulse too long");
endmodule : cond_skip_branch_unit
`default_nettype wire

// File: dv/prog_mem.sv
/*
 * Program store model: reports whether the instruction after the one
 * at pc is two words long. Assumes word addressing of pc.
 */
`timescale 1ns/10ps
`default_nettype none
module prog_mem (
    // Fetch address
    input wire logic [15:0] pc_i,
    // Length of the following instruction
    output logic two_word_o
);
    // Odd addresses are followed by a two-word instruction
    assign two_word_o = pc_i[0];
endmodule : prog_mem
`default_nettype wire

// File: dv/cond_skip_branch_unit_tb.sv
/*
 * Bench for the skip and branch unit: issues every operation and
 * checks program counter, cost and flags. Assumes the prog_mem model.
 */
`timescale 1ns/10ps
`default_nettype none
module cond_skip_branch_unit_tb;
    import flow_pkg::*;
    // Stimulus
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic issue_i = 1'b0;
    flow_op_t op_i = OP_NONE;
    logic [2:0] bit_sel_i = 3'h0;
    logic [OFS_W-1:0] offset_i = 7'h00;
    logic [7:0] reg_val_i = 8'h00;
    logic [7:0] io_val_i = 8'h00;
    logic [7:0] flags_i = 8'h00;
    // Observed
    wire logic next_two_word_i;
    logic [PC_W-1:0] pc_o;
    logic busy_o;
    logic taken_o;
    logic [7:0] flags_o;
    int err_count = 0;
    int cmp_count = 0;

    cond_skip_branch_unit cond_skip_branch_unit_i (.sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i), .issue_i(issue_i), .op_i(op_i),
        .bit_sel_i(bit_sel_i), .offset_i(offset_i),
        .next_two_word_i(next_two_word_i), .reg_val_i(reg_val_i),
        .io_val_i(io_val_i), .flags_i(flags_i), .pc_o(pc_o),
        .busy_o(busy_o), .taken_o(taken_o), .flags_o(flags_o));
    prog_mem prog_mem_i (.pc_i(pc_o), .two_word_o(next_two_word_i));

    // Clock at 200 MHz
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // Compare one result
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    // Expected decision of an operation
    function automatic logic hit(flow_op_t op, logic [2:0] b,
        logic [7:0] r, logic [7:0] io, logic [7:0] fl);
        case (op)
            OP_SKIP_REG_CLR: return !r[b];
            OP_SKIP_REG_SET: return r[b];
            OP_SKIP_IO_CLR: return !io[b];
            OP_SKIP_IO_SET: return io[b];
            OP_BR_FLAG_SET: return fl[b];
            OP_BR_FLAG_CLR: return !fl[b];
            OP_BR_EQ: return fl[FLAG_Z];
            OP_BR_NE: return !fl[FLAG_Z];
            OP_BR_CS: return fl[FLAG_C];
            default: return !fl[FLAG_C];
        endcase
    endfunction : hit

    // Issue one operation, check pc, pulse, flags and cost
    task automatic run(input flow_op_t op, input logic [2:0] b,
        input logic [6:0] k, input logic [7:0] r, input logic [7:0] io,
        input logic [7:0] fl);
        logic [15:0] pc0;
        logic [15:0] exp;
        logic t;
        logic w;
        int n;
        pc0 = pc_o;
        t = hit(op, b, r, io, fl);
        @(posedge sys_clk_i);
        issue_i <= 1'b1;
        op_i <= op;
        bit_sel_i <= b;
        offset_i <= k;
        reg_val_i <= r;
        io_val_i <= io;
        flags_i <= fl;
        #1 w = next_two_word_i;
        exp = pc0 + 16'h0001;
        if (t && op <= OP_SKIP_IO_SET) begin
            exp = pc0 + (w ? 16'h0003 : 16'h0002);
        end else if (t) begin
            exp = pc0 + {{9{k[6]}}, k} + 16'h0001;
        end
        @(posedge sys_clk_i);
        issue_i <= 1'b0;
        #1 cmp(pc_o, exp);
        cmp({15'h0000, taken_o}, {15'h0000, t});
        cmp({8'h00, flags_o}, {8'h00, fl});
        n = 0;
        while (busy_o === 1'b1 && n < 4) begin
            @(posedge sys_clk_i);
            #1 n++;
        end
        cmp(16'(n), !t ? 16'h0 : (op <= OP_SKIP_IO_SET && w) ? 16'h2 : 16'h1);
    endtask : run

    // Every skip, bit clear and set, over one- and two-word neighbours;
    // the untested operand holds the opposite bit to catch a mixed source
    task automatic t_skips;
        logic [7:0] v;
        logic [7:0] r;
        logic [7:0] io;
        for (int o = 1; o <= 4; o++) begin
            for (int i = 0; i < 4; i++) begin
                v = i[0] ? 8'h80 : 8'h7f;
                r = (o > 2) ? ~v : v;
                io = (o > 2) ? v : ~v;
                run(flow_op_t'(o), 3'h7, 7'h00, r, io,
                    8'h00);
            end
        end
    endtask : t_skips

    // Every branch, flag set and clear, extreme offsets
    task automatic t_branches;
        for (int o = 5; o <= 10; o++) begin
            for (int v = 0; v < 2; v++) begin
                run(flow_op_t'(o), 3'h7, v ? 7'h40 : 7'h3f,
                    8'h00, 8'h00, v ? 8'ha3 : 8'h5c);
            end
        end
    endtask : t_branches

    // Each bit alone, the same in every operand, so a wrong bit shows
    task automatic t_bit_select;
        logic [7:0] v;
        for (int o = 1; o <= 10; o++) begin
            for (int b = 0; b < 8; b++) begin
                v = 8'h01 << b;
                run(flow_op_t'(o), 3'(b), 7'h02,
                    v, v, v);
            end
        end
    endtask : t_bit_select

    // Issue held through the busy cycle is ignored
    task automatic t_refused;
        logic [15:0] pc0;
        pc0 = pc_o;
        @(posedge sys_clk_i);
        issue_i <= 1'b1;
        op_i <= OP_BR_EQ;
        offset_i <= 7'h05;
        flags_i <= 8'h02;
        repeat (2) @(posedge sys_clk_i);
        issue_i <= 1'b0;
        #1 cmp(pc_o, pc0 + 16'h0006);
        @(posedge sys_clk_i);
        #1 cmp({15'h0000, busy_o}, 16'h0000);
    endtask : t_refused

    // Verdict and end of run
    task automatic close_out;
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    // Watchdog
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        err_count++;
        close_out();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        #1 cmp(pc_o, 16'h0000);
        cmp({15'h0000, busy_o}, 16'h0000);
        t_skips();
        t_branches();
        t_bit_select();
        t_refused();
        close_out();
    end
endmodule : cond_skip_branch_unit_tb
`default_nettype wire
